/* File: include/boe_pkg.sv */
package boe_pkg;

    // =====================================================
    // widths and opcode fields
    localparam int WORD_W = 16;
    localparam int DATA_W = 8;
    localparam int PC_W = 21;
    localparam logic [3:0] OPC_HI_ZERO = 4'h0;
    localparam logic [3:0] OPC_HI_FILL = 4'hF;
    localparam logic [5:0] OPC_COMPLEMENT_FILE_OP = 6'h07;
    localparam logic [6:0] OPC_COMPARE_SKIP_EQUAL_OP = 7'h31;
    localparam logic [6:0] OPC_NEGATE_FILE_OP = 7'h36;
    localparam logic [14:0] OPC_RETURN_FROM_IRQ_OP = 15'h0008;
    localparam logic [7:0] OPC_RETURN_WITH_LITERAL_OP = 8'h0C;
    localparam logic [7:0] IDX_LIMIT = 8'h5F;

    // =====================================================
    // reset values
    localparam logic [7:0] RST_WREG = 8'h00;
    localparam logic [4:0] RST_FLAGS = 5'h00;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [PC_W-1:0] RST_PC = 21'h000000;

    // =====================================================
    // flag bit positions in the status byte
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;

    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } boe_phase_e;

    typedef enum logic [1:0] {
        EX_RUN,
        EX_IDLE
    } boe_exec_e;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] data;
        logic wr;
        logic rd;
    } boe_mem_s;

endpackage : boe_pkg

/* File: src/boe_exec.sv */
`timescale 1ns/100ps
`default_nettype none

module boe_exec
    import boe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WORD_W-1:0] opcode,
    input wire logic opcodeValid,
    input wire logic nextIsTwoWord,
    input wire logic extendedSet,
    input wire logic highPrioActive,
    input wire logic [11:0] indexBase,
    input wire logic [DATA_W-1:0] memRdData,
    input wire logic [PC_W-1:0] stackTop,
    input wire logic [DATA_W-1:0] workingShadow,
    input wire logic [4:0] flagsShadow,
    input wire logic [3:0] bankSelectShadow,
    output logic [DATA_W-1:0] workingReg,
    output logic [4:0] flagsReg,
    output logic [3:0] bankSelectReg,
    output logic [PC_W-1:0] progCounter,
    output logic pcLoad,
    output logic stackPop,
    output logic highPrioIrqEnable,
    output logic lowPrioIrqEnable,
    output boe_mem_s memPort,
    output logic [1:0] phase,
    output logic busy
);

    // =====================================================
    // operand decode
    function automatic logic [11:0] fileAddr(input logic [7:0] f, input logic a,
            input logic ext, input logic [3:0] bank, input logic [11:0] base);
        if (a) begin
            fileAddr = {bank, f};
        end else if (ext && f <= IDX_LIMIT) begin
            fileAddr = base + {4'h0, f};
        end else if (f[7]) begin
            fileAddr = {4'hF, f};
        end else begin
            fileAddr = {4'h0, f};
        end
    endfunction : fileAddr

    logic isComf, isCpfseq, isNegf, isRetfie, isRetlw, isNop;
    always_comb begin
        // decode the latched word, not the pin, so all phases agree
        isComf = cur[15:10] == OPC_COMPLEMENT_FILE_OP;
        isCpfseq = cur[15:9] == OPC_COMPARE_SKIP_EQUAL_OP;
        isNegf = cur[15:9] == OPC_NEGATE_FILE_OP;
        isRetfie = cur[15:1] == OPC_RETURN_FROM_IRQ_OP;
        isRetlw = cur[15:8] == OPC_RETURN_WITH_LITERAL_OP;
        isNop = cur == 16'h0000 || cur[15:12] == OPC_HI_FILL;
    end

    // =====================================================
    // state
    boe_phase_e ph, next_ph;
    boe_exec_e ex, next_ex;
    logic [1:0] idleLeft, next_idleLeft;
    logic [15:0] cur, next_cur;
    logic [DATA_W-1:0] next_workingReg;
    logic [4:0] next_flagsReg;
    logic [3:0] next_bankSelectReg;
    logic [PC_W-1:0] next_progCounter;
    logic next_pcLoad, next_stackPop, next_hie, next_lie;
    boe_mem_s next_memPort;
    logic [11:0] addr;
    logic [DATA_W-1:0] res;
    logic [8:0] sum;
    logic [4:0] lowSum;

    always_comb begin
        next_ph = boe_phase_e'(ph + 2'd1);
        next_ex = ex;
        next_idleLeft = idleLeft;
        next_cur = cur;
        next_workingReg = workingReg;
        next_flagsReg = flagsReg;
        next_bankSelectReg = bankSelectReg;
        next_progCounter = progCounter;
        next_pcLoad = 1'b0;
        next_stackPop = 1'b0;
        next_hie = highPrioIrqEnable;
        next_lie = lowPrioIrqEnable;
        next_memPort = '0;
        addr = fileAddr(cur[7:0], cur[8], extendedSet, bankSelectReg, indexBase);
        res = 8'h00;
        sum = 9'h000;
        lowSum = 5'h00;
        case (ph)
            PH_Q1: begin
                // latch only at Q1 so mid-cycle opcode changes are harmless
                if (ex == EX_IDLE) begin
                    next_cur = 16'h0000;
                end else begin
                    next_cur = opcodeValid ? opcode : 16'h0000;
                end
            end
            PH_Q2: begin
                if (ex == EX_RUN && (isComf || isCpfseq || isNegf)) begin
                    next_memPort.addr = addr;
                    next_memPort.rd = 1'b1;
                end
            end
            PH_Q3: begin
                if (ex == EX_RUN && isComf) begin
                    res = ~memRdData;
                    next_flagsReg[FLAG_N] = res[7];
                    next_flagsReg[FLAG_Z] = res == 8'h00;
                    if (cur[9]) begin
                        next_memPort = '{addr: addr, data: res, wr: 1'b1, rd: 1'b0};
                    end else begin
                        next_workingReg = res;
                    end
                end else if (ex == EX_RUN && isNegf) begin
                    sum = {1'b0, ~memRdData} + 9'h001;
                    lowSum = {1'b0, ~memRdData[3:0]} + 5'h01;
                    res = sum[7:0];
                    next_flagsReg[FLAG_N] = res[7];
                    next_flagsReg[FLAG_Z] = res == 8'h00;
                    next_flagsReg[FLAG_C] = sum[8];
                    next_flagsReg[FLAG_DC] = lowSum[4];
                    next_flagsReg[FLAG_OV] = memRdData == 8'h80;
                    next_memPort = '{addr: addr, data: res, wr: 1'b1, rd: 1'b0};
                end
            end
            default: begin
                next_ex = EX_RUN;
                if (ex == EX_IDLE) begin
                    next_idleLeft = idleLeft - 2'd1;
                    if (idleLeft != 2'd1) begin
                        next_ex = EX_IDLE;
                    end
                end else if (isCpfseq) begin
                    // no result and no flags, only the skip decision
                    if (memRdData == workingReg) begin
                        next_ex = EX_IDLE;
                        next_idleLeft = nextIsTwoWord ? 2'd2 : 2'd1;
                    end
                end else if (isRetfie) begin
                    next_progCounter = stackTop;
                    next_pcLoad = 1'b1;
                    next_stackPop = 1'b1;
                    next_ex = EX_IDLE;
                    next_idleLeft = 2'd1;
                    if (highPrioActive) begin
                        next_hie = 1'b1;
                    end else begin
                        next_lie = 1'b1;
                    end
                    if (cur[0]) begin
                        next_workingReg = workingShadow;
                        next_flagsReg = flagsShadow;
                        next_bankSelectReg = bankSelectShadow;
                    end
                end else if (isRetlw) begin
                    next_workingReg = cur[7:0];
                    // pc latches are not outputs here, so they stay as they are
                    next_progCounter = stackTop;
                    next_pcLoad = 1'b1;
                    next_stackPop = 1'b1;
                    next_ex = EX_IDLE;
                    next_idleLeft = 2'd1;
                end else if (isNop) begin
                    next_ex = EX_RUN; // no register or flag moves
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ph <= PH_Q1;
            ex <= EX_RUN;
            idleLeft <= 2'd0;
            cur <= 16'h0000;
            workingReg <= RST_WREG;
            flagsReg <= RST_FLAGS;
            bankSelectReg <= RST_BANK;
            progCounter <= RST_PC;
            pcLoad <= 1'b0;
            stackPop <= 1'b0;
            highPrioIrqEnable <= 1'b0;
            lowPrioIrqEnable <= 1'b0;
            memPort <= '0;
            phase <= 2'd0;
            busy <= 1'b0;
        end else begin
            ph <= next_ph;
            ex <= next_ex;
            idleLeft <= next_idleLeft;
            cur <= next_cur;
            workingReg <= next_workingReg;
            flagsReg <= next_flagsReg;
            bankSelectReg <= next_bankSelectReg;
            progCounter <= next_progCounter;
            pcLoad <= next_pcLoad;
            stackPop <= next_stackPop;
            highPrioIrqEnable <= next_hie;
            lowPrioIrqEnable <= next_lie;
            memPort <= next_memPort;
            phase <= next_ph;
            busy <= next_ex == EX_IDLE;
        end
    end

endmodule : boe_exec

`default_nettype wire

/* File: tb/boe_exec_properties.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========
// port properties
module boe_exec_properties
    import boe_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [PC_W-1:0] stackTop,
    input wire logic [PC_W-1:0] progCounter,
    input wire logic pcLoad,
    input wire logic stackPop,
    input wire logic busy,
    input wire logic highPrioIrqEnable,
    input wire logic lowPrioIrqEnable,
    input wire boe_mem_s memPort
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_popPair; pcLoad |-> stackPop; endproperty
    a_popPair: assert property (p_popPair) else $error("pc load without pop");
    property p_pcFromStack; pcLoad |-> progCounter == $past(stackTop); endproperty
    a_pcFromStack: assert property (p_pcFromStack) else $error("pc not stack top");
    property p_popBusy; stackPop |-> busy; endproperty
    a_popBusy: assert property (p_popBusy) else $error("no idle cycle after pop");
    property p_pcHold; !pcLoad |-> $stable(progCounter); endproperty
    a_pcHold: assert property (p_pcHold) else $error("pc moved without load");
    property p_irqOnPop;
        $rose(highPrioIrqEnable) || $rose(lowPrioIrqEnable) |-> stackPop;
    endproperty
    a_irqOnPop: assert property (p_irqOnPop) else $error("enable set off return");
    property p_wrAfterRd; memPort.wr |-> $past(memPort.rd); endproperty
    a_wrAfterRd: assert property (p_wrAfterRd) else $error("write without read");
    property p_wrAddr; memPort.wr |-> memPort.addr == $past(memPort.addr); endproperty
    a_wrAddr: assert property (p_wrAddr) else $error("write address moved");
    property p_busyNoRd; busy |-> !memPort.rd; endproperty
    a_busyNoRd: assert property (p_busyNoRd) else $error("read in idle cycle");
endmodule : boe_exec_properties

`default_nettype wire

/* File: tb/boe_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========
// data memory model
module boe_mem_model
    import boe_pkg::*;
(
    input wire logic clk,
    input wire boe_mem_s memPort,
    output logic [DATA_W-1:0] memRdData
);
    logic [11:0] lastAddr;
    logic held;
    // fixed pattern, writes ignored, so every read is predictable
    function automatic logic [7:0] patOf(input logic [11:0] ad);
        return ad[7:0] ^ {4'h0, ad[11:8]} ^ 8'hA5;
    endfunction : patOf
    // the address leaves the port after Q3, so keep it for the Q4 compare
    always @(posedge clk) begin
        held <= memPort.rd === 1'b1;
        if (memPort.rd === 1'b1) lastAddr <= memPort.addr;
    end
    // valid only through Q3 and Q4, inverse otherwise
    assign memRdData = memPort.rd === 1'b1 ? patOf(memPort.addr)
                       : (held ? patOf(lastAddr) : ~patOf(lastAddr));
endmodule : boe_mem_model

`default_nettype wire

/* File: tb/tb_boe_exec.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_boe_exec
    import boe_pkg::*;
;
    logic clk = 0, rst = 1, opcodeValid = 0, nextIsTwoWord = 0;
    logic extendedSet = 0, highPrioActive = 0;
    logic [15:0] opcode = 16'h0000;
    logic [11:0] indexBase = 12'h000, wa;
    logic [7:0] workingShadow = 8'h00, w = 8'h00, x, wd, f, memRdData, workingReg;
    logic [4:0] flagsShadow = 5'h00, flagsReg;
    logic [3:0] bankSelectShadow = 4'h0, bank = 4'h0, bankSelectReg;
    logic [20:0] stackTop = 21'h000000, progCounter;
    logic pcLoad, stackPop, highPrioIrqEnable, lowPrioIrqEnable, busy;
    logic [1:0] phase;
    boe_mem_s memPort;
    int errors = 0, n_checks = 0, seed = 88, cyc = 0, k, a, s, nb, eq;

    boe_exec dut (
        .clk(clk),
        .rst(rst),
        .opcode(opcode),
        .opcodeValid(opcodeValid),
        .nextIsTwoWord(nextIsTwoWord),
        .extendedSet(extendedSet),
        .highPrioActive(highPrioActive),
        .indexBase(indexBase),
        .memRdData(memRdData),
        .stackTop(stackTop),
        .workingShadow(workingShadow),
        .flagsShadow(flagsShadow),
        .bankSelectShadow(bankSelectShadow),
        .workingReg(workingReg),
        .flagsReg(flagsReg),
        .bankSelectReg(bankSelectReg),
        .progCounter(progCounter),
        .pcLoad(pcLoad),
        .stackPop(stackPop),
        .highPrioIrqEnable(highPrioIrqEnable),
        .lowPrioIrqEnable(lowPrioIrqEnable),
        .memPort(memPort),
        .phase(phase),
        .busy(busy)
    );
    boe_mem_model mem (.clk(clk), .memPort(memPort), .memRdData(memRdData));

    // ==========
    // helpers
    function automatic logic [7:0] pat(input logic [11:0] ad);
        return ad[7:0] ^ {4'h0, ad[11:8]} ^ 8'hA5;
    endfunction : pat
    function automatic logic [11:0] adr(input logic [7:0] fv, input logic av);
        if (extendedSet && !av && fv <= IDX_LIMIT) return indexBase + {4'h0, fv};
        if (!av) return {fv[7] ? 4'hF : 4'h0, fv};
        return {bank, fv};
    endfunction : adr
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (e !== g) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : cmp
    task automatic run(input logic [15:0] op);
        {wa, wd} = 20'h00000;
        nb = 0;
        do @(negedge clk); while (phase !== 2'h0 || busy !== 1'b0);
        opcode = op;
        opcodeValid = 1;
        @(negedge clk) opcode = 16'h0000;
        repeat (7) @(negedge clk) begin
            if (memPort.wr === 1'b1) {wa, wd} = {memPort.addr, memPort.data};
            if (busy === 1'b1) nb++;
        end
    endtask : run
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // ==========
    // clock, timeout, sequence
    initial forever #5 clk = ~clk;
    // 40 short instructions need about 490 cycles
    always @(posedge clk) if (++cyc == 3000) begin errors++; end_of_test(); end
    initial begin
        repeat (6) @(negedge clk);
        rst = 0;
        for (int i = 0; i < 40; i++) begin
            k = i == 0 ? 1 : $unsigned($random(seed)) % 6;
            f = i == 0 ? 8'h9F : 8'($random(seed));
            a = i == 0 ? 1 : $random(seed) & 1;
            {extendedSet, highPrioActive, nextIsTwoWord} = 3'($random(seed));
            s = $random(seed) & 1;
            indexBase = 12'($random(seed));
            stackTop = 21'($random(seed));
            {workingShadow, flagsShadow, bankSelectShadow} = 17'($random(seed));
            case (k)
                0: begin
                    run({OPC_COMPLEMENT_FILE_OP, 1'b0, 1'(a), f});
                    x = ~pat(adr(f, 1'(a)));
                    w = x;
                end
                1: begin
                    run({OPC_NEGATE_FILE_OP, 1'(a), f});
                    x = -pat(adr(f, 1'(a)));
                    cmp("wrData", x, wd);
                    cmp("wrAddr", adr(f, 1'(a)), wa);
                end
                2: begin
                    run({OPC_RETURN_WITH_LITERAL_OP, f});
                    w = f;
                    cmp("pc", stackTop, progCounter);
                end
                3: begin
                    run({OPC_RETURN_FROM_IRQ_OP, 1'(s)});
                    if (s) {w, bank} = {workingShadow, bankSelectShadow};
                    if (s) cmp("flags", flagsShadow, flagsReg);
                    cmp("pc", stackTop, progCounter);
                    cmp("irqEn", 1, highPrioActive ? highPrioIrqEnable : lowPrioIrqEnable);
                end
                4: begin
                    // half the time pick the one address whose data equals W
                    if (s) begin
                        a = 1;
                        f = w ^ 8'hA5 ^ {4'h0, bank};
                    end
                    eq = int'(pat(adr(f, 1'(a))) == w);
                    run({OPC_COMPARE_SKIP_EQUAL_OP, 1'(a), f});
                    cmp("skipCycles", eq ? (nextIsTwoWord ? 5 : 4) : 0, nb);
                end
                default: run(s ? {4'hF, 12'($random(seed))} : 16'h0000);
            endcase
            if (k < 2) cmp("nz", {x[7], x == 0}, {flagsReg[FLAG_N], flagsReg[FLAG_Z]});
            cmp("w", w, workingReg);
            cmp("bank", bank, bankSelectReg);
            $display("test %0d kind %0d done", i, k);
        end
        end_of_test();
    end
endmodule : tb_boe_exec

bind boe_exec boe_exec_properties chk (
    .clk(clk),
    .rst(rst),
    .stackTop(stackTop),
    .progCounter(progCounter),
    .pcLoad(pcLoad),
    .stackPop(stackPop),
    .busy(busy),
    .highPrioIrqEnable(highPrioIrqEnable),
    .lowPrioIrqEnable(lowPrioIrqEnable),
    .memPort(memPort)
);

`default_nettype wire
